// ==== hdl/ddrsr_regs.svh ====
`ifndef DDRSR_REGS_SVH
`define DDRSR_REGS_SVH

// ==========================================================
// Clock
`define DDRSR_TCK_NS        10

// ==========================================================
// Times in ns
`define DDRSR_TRP_NS        15
`define DDRSR_TRFC_NS       110
`define DDRSR_TREFI_NS      7800
`define DDRSR_TXS_NS        120
`define DDRSR_TCKE_NS       8
`define DDRSR_TCKSRE_NS     10
`define DDRSR_TCKSRX_NS     10

// ==========================================================
// Times in clock cycles
`define DDRSR_TXSDLL_CK     512
`define DDRSR_ODTOFF_CK     6

// ==========================================================
// Conversions: least rounds up, longest rounds down
`define DDRSR_CYC_MIN(ns) \
	((((ns) + `DDRSR_TCK_NS - 1) / `DDRSR_TCK_NS) < 1 ? 1 : \
	 (((ns) + `DDRSR_TCK_NS - 1) / `DDRSR_TCK_NS))
`define DDRSR_CYC_MAX(ns) \
	(((ns) / `DDRSR_TCK_NS) < 1 ? 1 : ((ns) / `DDRSR_TCK_NS))

// ==========================================================
// Refresh credit limits
`define DDRSR_MAX_POSTPONE  8
`define DDRSR_MAX_PULLIN    8

// ==========================================================
// Widths and bit positions
`define DDRSR_ROW_W         16
`define DDRSR_ADDR_W        14
`define DDRSR_BA_W          3
`define DDRSR_A10_BIT       10

`endif

// ==== hdl/ddrsr_pkg.sv ====
package ddrsr_pkg;

	// ==========================================================
	// Command encoding {cs_n, ras_n, cas_n, we_n}
	typedef enum logic [3:0] {
		DDRSR_CMD_REF  = 4'h1,
		DDRSR_CMD_PREA = 4'h2,
		DDRSR_CMD_ACT  = 4'h3,
		DDRSR_CMD_NOP  = 4'h7,
		DDRSR_CMD_DES  = 4'hF
	} ddrsr_cmd_t;

	// ==========================================================
	// Memory device states
	typedef enum logic [1:0] {
		DDRSR_D_IDLE = 2'h0,
		DDRSR_D_REF  = 2'h1,
		DDRSR_D_SR   = 2'h3,
		DDRSR_D_XS   = 2'h2
	} ddrsr_dstate_t;

	// ==========================================================
	// Controller states
	typedef enum logic [3:0] {
		DDRSR_C_IDLE  = 4'h0,
		DDRSR_C_PRE   = 4'h1,
		DDRSR_C_TRP   = 4'h3,
		DDRSR_C_REF   = 4'h2,
		DDRSR_C_ODT   = 4'h6,
		DDRSR_C_SRE   = 4'h7,
		DDRSR_C_SR    = 4'h5,
		DDRSR_C_CKRX  = 4'h4,
		DDRSR_C_XS    = 4'hC,
		DDRSR_C_XSDLL = 4'hD
	} ddrsr_cstate_t;

endpackage : ddrsr_pkg

// ==== hdl/ddrsr_if.sv ====
`timescale 1ns/100ps
`include "ddrsr_regs.svh"

interface ddrsr_if;
	logic                      reset_n;
	logic                      cs_n;
	logic                      ras_n;
	logic                      cas_n;
	logic                      we_n;
	logic                      cke;
	logic                      odt;
	logic                      ck_stop;
	logic [`DDRSR_ADDR_W-1:0]  addr;
	logic [`DDRSR_BA_W-1:0]    ba;

	modport ctrl (
		output reset_n, cs_n, ras_n, cas_n, we_n, cke, odt, ck_stop,
		output addr, ba
	);

	modport dram (
		input reset_n, cs_n, ras_n, cas_n, we_n, cke, odt, ck_stop,
		input addr, ba
	);
endinterface : ddrsr_if

// ==== hdl/ddrsr_dram.sv ====
`timescale 1ns/100ps
`include "ddrsr_regs.svh"

module ddrsr_dram #(
	parameter int TW       = 10,
	parameter int T_RFC    = `DDRSR_CYC_MIN(`DDRSR_TRFC_NS),
	parameter int T_XS     = `DDRSR_CYC_MIN(`DDRSR_TXS_NS),
	parameter int T_REFI   = `DDRSR_CYC_MAX(`DDRSR_TREFI_NS)
) (
	// Clock and reset
	input  wire logic                      clk,
	input  wire logic                      rst,
	// Memory bus
	ddrsr_if.dram                          mem,
	// Mode setting
	input  wire logic                      dll_en,
	// Status
	output logic                           ref_active_r,
	output logic                           int_ref_r,
	output logic                           in_sr_r,
	output logic                           dll_on_r,
	output logic                           dll_reset_r,
	output logic                           banks_idle_r,
	output logic [`DDRSR_ROW_W-1:0]        ref_row_r
);
	import ddrsr_pkg::*;

	// ==========================================================
	// Parameter check
	generate
		if (T_RFC >= (1 << TW) || T_XS >= (1 << TW) ||
		    T_REFI >= (1 << TW) || T_RFC < 1) begin : g_bad
			$error("ddrsr_dram: timer width too small");
		end
	endgenerate

	localparam logic [TW-1:0] C_RFC  = TW'(T_RFC - 1);
	localparam logic [TW-1:0] C_XS   = TW'(T_XS - 1);
	localparam logic [TW-1:0] C_REFI = TW'(T_REFI - 1);

	// ==========================================================
	// Command decode
	function automatic ddrsr_cmd_t dec_cmd(input logic c, input logic r,
		input logic a, input logic w);
		dec_cmd = ddrsr_cmd_t'({c, r, a, w});
	endfunction : dec_cmd

	ddrsr_dstate_t          st_r;
	ddrsr_dstate_t          st_nxt;
	logic [TW-1:0]          tmr_r;
	logic                   cke_q_r;

	wire ddrsr_cmd_t cmd     = dec_cmd(mem.cs_n, mem.ras_n, mem.cas_n,
	                                   mem.we_n);
	wire        is_ref_enc   = (cmd == DDRSR_CMD_REF);
	wire        ref_cmd      = cke_q_r && mem.cke && is_ref_enc;
	wire        sre_cmd      = cke_q_r && !mem.cke && is_ref_enc;
	wire        tmr_done     = (tmr_r == '0);
	wire        in_idle      = (st_r == DDRSR_D_IDLE);
	wire        in_sr        = (st_r == DDRSR_D_SR);
	// Clock and all inputs but CKE and RESET ignored in self-refresh
	wire        sr_exit      = in_sr && mem.cke;
	wire        sr_tick      = in_sr && tmr_done;
	wire        start_ref    = in_idle && ref_cmd;
	wire        start_sre    = in_idle && sre_cmd;
	wire        row_step     = start_ref || start_sre || sr_tick;

	// ==========================================================
	// Next state
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			DDRSR_D_IDLE: begin
				if (start_ref)
					st_nxt = DDRSR_D_REF;
				else if (start_sre)
					st_nxt = DDRSR_D_SR;
			end
			DDRSR_D_REF: begin
				if (tmr_done)
					st_nxt = DDRSR_D_IDLE;
			end
			DDRSR_D_SR: begin
				if (sr_exit)
					st_nxt = DDRSR_D_XS;
			end
			DDRSR_D_XS: begin
				if (tmr_done)
					st_nxt = DDRSR_D_IDLE;
			end
			default: st_nxt = DDRSR_D_IDLE;
		endcase
		if (!mem.reset_n)
			st_nxt = DDRSR_D_IDLE;
	end

	// ==========================================================
	// State and timer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r    <= DDRSR_D_IDLE;
			tmr_r   <= '0;
			cke_q_r <= 1'b0;
		end else begin
			st_r    <= st_nxt;
			cke_q_r <= mem.cke && mem.reset_n;
			if (!mem.reset_n)
				tmr_r <= '0;
			else if (start_ref)
				tmr_r <= C_RFC;
			else if (start_sre || sr_tick)
				tmr_r <= C_REFI;
			else if (sr_exit)
				tmr_r <= C_XS;
			else if (!tmr_done)
				tmr_r <= tmr_r - 1'b1;
		end
	end

	// ==========================================================
	// Refresh row counter and status
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ref_row_r    <= '0;
			ref_active_r <= 1'b0;
			int_ref_r    <= 1'b0;
			in_sr_r      <= 1'b0;
			dll_on_r     <= 1'b0;
			dll_reset_r  <= 1'b0;
			banks_idle_r <= 1'b1;
		end else if (!mem.reset_n) begin
			ref_row_r    <= '0;
			ref_active_r <= 1'b0;
			int_ref_r    <= 1'b0;
			in_sr_r      <= 1'b0;
			dll_on_r     <= 1'b0;
			dll_reset_r  <= 1'b0;
			banks_idle_r <= 1'b1;
		end else begin
			if (row_step)
				ref_row_r <= ref_row_r + 1'b1;
			ref_active_r <= (st_nxt == DDRSR_D_REF);
			// First internal refresh starts on entry, well within tCKE
			int_ref_r    <= start_sre || sr_tick;
			in_sr_r      <= (st_nxt == DDRSR_D_SR);
			dll_reset_r  <= sr_exit && dll_en;
			if (start_sre)
				dll_on_r <= 1'b0;
			else if (sr_exit)
				dll_on_r <= dll_en;
			else if (in_idle)
				dll_on_r <= dll_en;
			if (st_r == DDRSR_D_REF && tmr_done)
				banks_idle_r <= 1'b1;
			else if (start_ref)
				banks_idle_r <= 1'b0;
			else if (in_idle && cmd == DDRSR_CMD_ACT && cke_q_r)
				banks_idle_r <= 1'b0;
			else if (in_idle && cmd == DDRSR_CMD_PREA && cke_q_r)
				banks_idle_r <= 1'b1;
		end
	end

endmodule : ddrsr_dram

// ==== hdl/ddrsr_ctrl.sv ====
`timescale 1ns/100ps
`include "ddrsr_regs.svh"


module ddrsr_ctrl #(
	parameter int TW       = 10,
	parameter int T_RP     = `DDRSR_CYC_MIN(`DDRSR_TRP_NS),
	parameter int T_RFC    = `DDRSR_CYC_MIN(`DDRSR_TRFC_NS),
	parameter int T_REFI   = `DDRSR_CYC_MAX(`DDRSR_TREFI_NS),
	parameter int T_XS     = `DDRSR_CYC_MIN(`DDRSR_TXS_NS),
	parameter int T_CKE    = `DDRSR_CYC_MIN(`DDRSR_TCKE_NS),
	parameter int T_CKSRE  = `DDRSR_CYC_MIN(`DDRSR_TCKSRE_NS),
	parameter int T_CKSRX  = `DDRSR_CYC_MIN(`DDRSR_TCKSRX_NS),
	parameter int T_XSDLL  = `DDRSR_TXSDLL_CK,
	parameter int T_ODTOFF = `DDRSR_ODTOFF_CK
) (
	// Clock and reset
	input  wire logic                      clk,
	input  wire logic                      rst,
	// Memory bus
	ddrsr_if.ctrl                          mem,
	// User requests
	input  wire logic                      sr_req,
	input  wire logic                      defer,
	input  wire logic                      pull_in,
	input  wire logic                      banks_open,
	input  wire logic                      odt_req,
	// User status
	output logic                           busy_r,
	output logic                           in_sr_r,
	output logic                           dll_ready_r,
	output logic signed [4:0]              credit_r
);
	import ddrsr_pkg::*;

	// ==========================================================
	// Parameter check
	localparam int T_SRMIN = (T_CKSRE > T_CKE) ? T_CKSRE : T_CKE;
	generate
		if (T_REFI >= (1 << TW) || T_XSDLL >= (1 << TW) ||
		    T_RFC >= (1 << TW) || T_XS >= T_XSDLL ||
		    T_ODTOFF < 1 || T_RP < 1) begin : g_bad
			$error("ddrsr_ctrl: timing parameters not servable");
		end
	endgenerate

	localparam logic [TW-1:0] C_RP     = TW'(T_RP - 1);
	localparam logic [TW-1:0] C_RFC    = TW'(T_RFC - 1);
	localparam logic [TW-1:0] C_REFI   = TW'(T_REFI - 1);
	localparam logic [TW-1:0] C_XS     = TW'(T_XS - 1);
	localparam logic [TW-1:0] C_XSDLL  = TW'(T_XSDLL - T_XS - 1);
	localparam logic [TW-1:0] C_SRMIN  = TW'(T_SRMIN - 1);
	localparam logic [TW-1:0] C_CKSRX  = TW'(T_CKSRX - 1);
	localparam logic [TW-1:0] C_ODTOFF = TW'(T_ODTOFF - 1);
	localparam logic signed [4:0] CR_MAX = 5'(`DDRSR_MAX_POSTPONE);
	localparam logic signed [4:0] CR_MIN = -5'(`DDRSR_MAX_PULLIN);

	ddrsr_cstate_t          st_r;
	ddrsr_cstate_t          st_nxt;
	logic [TW-1:0]          tmr_r;
	logic [TW-1:0]          tmr_nxt;
	logic [TW-1:0]          refi_r;
	logic                   dirty_r;
	logic                   pull_r;
	logic                   post_ref_ok_r;
	ddrsr_cmd_t             cmd_r;
	ddrsr_cmd_t             cmd_nxt;
	logic                   cke_r;
	logic                   odt_r;
	logic                   ck_stop_r;
	logic                   rst_n_r;

	// ==========================================================
	// Decode
	wire        tmr_done  = (tmr_r == '0);
	wire        in_idle   = (st_r == DDRSR_C_IDLE);
	wire        self_ref  = (st_r == DDRSR_C_SRE) || (st_r == DDRSR_C_SR) ||
	                        (st_r == DDRSR_C_CKRX);
	wire        refi_tick = (refi_r == '0) && !self_ref;
	wire        must_ref  = (credit_r >= CR_MAX);
	wire        want_ref  = must_ref || (credit_r > 0 && !defer) ||
	                        pull_r || !post_ref_ok_r;
	wire        go_pre    = in_idle && dirty_r;
	wire        go_ref    = in_idle && !dirty_r && want_ref;
	wire        go_sr     = in_idle && !dirty_r && !want_ref && sr_req &&
	                        (credit_r <= 0) && post_ref_ok_r;
	wire        issue_ref = go_ref;
	wire        credit_dn = issue_ref && (credit_r > CR_MIN);

	// ==========================================================
	// Next state, timer and command
	always_comb begin
		st_nxt  = st_r;
		tmr_nxt = tmr_done ? tmr_r : tmr_r - 1'b1;
		cmd_nxt = DDRSR_CMD_NOP;
		case (st_r)
			DDRSR_C_IDLE: begin
				if (go_pre) begin
					st_nxt  = DDRSR_C_PRE;
					cmd_nxt = DDRSR_CMD_PREA;
				end else if (go_ref) begin
					st_nxt  = DDRSR_C_REF;
					tmr_nxt = C_RFC;
					cmd_nxt = DDRSR_CMD_REF;
				end else if (go_sr) begin
					st_nxt  = DDRSR_C_ODT;
					tmr_nxt = C_ODTOFF;
				end
			end
			DDRSR_C_PRE: begin
				st_nxt  = DDRSR_C_TRP;
				tmr_nxt = C_RP;
			end
			DDRSR_C_TRP: begin
				if (tmr_done)
					st_nxt = DDRSR_C_IDLE;
			end
			DDRSR_C_REF: begin
				if (tmr_done)
					st_nxt = DDRSR_C_IDLE;
			end
			DDRSR_C_ODT: begin
				if (tmr_done) begin
					st_nxt  = DDRSR_C_SRE;
					tmr_nxt = C_SRMIN;
					cmd_nxt = DDRSR_CMD_REF;
				end
			end
			DDRSR_C_SRE: begin
				cmd_nxt = DDRSR_CMD_DES;
				if (tmr_done)
					st_nxt = DDRSR_C_SR;
			end
			DDRSR_C_SR: begin
				cmd_nxt = DDRSR_CMD_DES;
				if (!sr_req) begin
					st_nxt  = DDRSR_C_CKRX;
					tmr_nxt = C_CKSRX;
				end
			end
			DDRSR_C_CKRX: begin
				cmd_nxt = DDRSR_CMD_DES;
				if (tmr_done) begin
					st_nxt  = DDRSR_C_XS;
					tmr_nxt = C_XS;
					cmd_nxt = DDRSR_CMD_NOP;
				end
			end
			DDRSR_C_XS: begin
				if (tmr_done) begin
					st_nxt  = DDRSR_C_XSDLL;
					tmr_nxt = C_XSDLL;
				end
			end
			DDRSR_C_XSDLL: begin
				if (tmr_done)
					st_nxt = DDRSR_C_IDLE;
			end
			default: st_nxt = DDRSR_C_IDLE;
		endcase
	end

	// ==========================================================
	// State, timer and pins
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r      <= DDRSR_C_IDLE;
			tmr_r     <= '0;
			cmd_r     <= DDRSR_CMD_DES;
			cke_r     <= 1'b0;
			odt_r     <= 1'b0;
			ck_stop_r <= 1'b0;
			rst_n_r   <= 1'b0;
		end else begin
			st_r      <= st_nxt;
			tmr_r     <= tmr_nxt;
			cmd_r     <= cmd_nxt;
			rst_n_r   <= 1'b1;
			// Low from entry through restart
			cke_r     <= !(st_nxt == DDRSR_C_SRE ||
			               st_nxt == DDRSR_C_SR ||
			               st_nxt == DDRSR_C_CKRX);
			odt_r     <= odt_req && (st_nxt == DDRSR_C_IDLE ||
			             st_nxt == DDRSR_C_PRE ||
			             st_nxt == DDRSR_C_TRP ||
			             st_nxt == DDRSR_C_REF);
			ck_stop_r <= (st_nxt == DDRSR_C_SR);
		end
	end

	// ==========================================================
	// Refresh interval and credit
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			refi_r        <= C_REFI;
			credit_r      <= '0;
			pull_r        <= 1'b0;
			dirty_r       <= 1'b1;
			post_ref_ok_r <= 1'b1;
		end else begin
			if (refi_tick)
				refi_r <= C_REFI;
			else if (!self_ref)
				refi_r <= refi_r - 1'b1;
			// Tick and refresh in one cycle cancel
			if (refi_tick && !credit_dn && credit_r < CR_MAX)
				credit_r <= credit_r + 5'sd1;
			else if (credit_dn && !refi_tick)
				credit_r <= credit_r - 5'sd1;
			if (pull_in)
				pull_r <= 1'b1;
			else if (issue_ref)
				pull_r <= 1'b0;
			if (banks_open)
				dirty_r <= 1'b1;
			else if (st_r == DDRSR_C_TRP && tmr_done)
				dirty_r <= 1'b0;
			if (st_r == DDRSR_C_CKRX && tmr_done)
				post_ref_ok_r <= 1'b0;
			else if (issue_ref)
				post_ref_ok_r <= 1'b1;
		end
	end

	// ==========================================================
	// User status
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busy_r      <= 1'b1;
			in_sr_r     <= 1'b0;
			dll_ready_r <= 1'b0;
		end else begin
			busy_r      <= (st_nxt != DDRSR_C_IDLE);
			in_sr_r     <= (st_nxt == DDRSR_C_SR);
			if (st_nxt == DDRSR_C_XSDLL && st_r == DDRSR_C_XS)
				dll_ready_r <= 1'b0;
			else if (st_nxt == DDRSR_C_IDLE)
				dll_ready_r <= 1'b1;
			else if (st_nxt == DDRSR_C_ODT)
				dll_ready_r <= 1'b0;
		end
	end

	// ==========================================================
	// Pin drive
	assign mem.reset_n = rst_n_r;
	assign mem.cs_n    = cmd_r[3];
	assign mem.ras_n   = cmd_r[2];
	assign mem.cas_n   = cmd_r[1];
	assign mem.we_n    = cmd_r[0];
	assign mem.cke     = cke_r;
	assign mem.odt     = odt_r;
	assign mem.ck_stop = ck_stop_r;
	// Precharge-all needs A10 high; address is otherwise unused
	assign mem.addr    = `DDRSR_ADDR_W'(1 << `DDRSR_A10_BIT);
	assign mem.ba      = '0;

endmodule : ddrsr_ctrl

// ==== dv/ddrsr_assertions.sv ====
`timescale 1ns/100ps

module ddrsr_assertions #(
	parameter int T_RP     = 2,
	parameter int T_RFC    = 4,
	parameter int T_REFI   = 20,
	parameter int T_XS     = 5,
	parameter int T_XSDLL  = 10,
	parameter int T_ODTOFF = 6,
	parameter int T_CKSRX  = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Memory bus
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic cke,
	input wire logic odt,
	input wire logic ck_stop
);
	import ddrsr_pkg::*;

	// ==========================================================
	// Decode and timers
	localparam int GAP_MAX = 9 * T_REFI;
	logic [3:0] cmd;
	logic       is_ref, is_pre, is_nop, exit_ev;
	logic       cke_r, sr_r, need_r;
	int         rp_r, rfc_r, xs_r, dll_r, odt_r, run_r, gap_r;

	assign cmd     = {cs_n, ras_n, cas_n, we_n};
	assign is_ref  = cmd == DDRSR_CMD_REF;
	assign is_pre  = cmd == DDRSR_CMD_PREA;
	assign is_nop  = cmd == DDRSR_CMD_NOP || cmd == DDRSR_CMD_DES;
	assign exit_ev = cke && !cke_r && sr_r;

	function automatic int dec(input int v);
		return v > 0 ? v - 1 : 0;
	endfunction : dec

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			{cke_r, sr_r, need_r} <= 3'h0;
			{rp_r, rfc_r, xs_r, dll_r, odt_r, gap_r} <= '0;
			run_r <= 15;
		end else begin
			cke_r  <= cke;
			sr_r   <= !exit_ev && (sr_r || ck_stop);
			need_r <= exit_ev || (need_r && !(is_ref && cke));
			rp_r   <= is_pre ? T_RP - 1 : dec(rp_r);
			rfc_r  <= is_ref && cke ? T_RFC - 1 : dec(rfc_r);
			xs_r   <= exit_ev ? T_XS - 1 : dec(xs_r);
			dll_r  <= exit_ev ? T_XSDLL - 1 : dec(dll_r);
			odt_r  <= odt ? 0 : (odt_r < 15 ? odt_r + 1 : 15);
			run_r  <= ck_stop ? 0 : (run_r < 15 ? run_r + 1 : 15);
			gap_r  <= is_ref || !cke ? 0 : gap_r + 1;
		end
	end

	// ==========================================================
	// Sequences and properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_ref; is_ref && cke; endsequence
	sequence s_sre; is_ref && !cke; endsequence
	sequence s_srx; exit_ev; endsequence

	property p_ref_cke; s_ref |-> cke_r; endproperty
	a_ref_cke: assert property (p_ref_cke) else $error("refresh cke");
	property p_ref_trp; s_ref |-> rp_r == 0; endproperty
	a_ref_trp: assert property (p_ref_trp) else $error("refresh trp");
	property p_trfc_nop; rfc_r != 0 |-> is_nop; endproperty
	a_trfc_nop: assert property (p_trfc_nop) else $error("trfc cmd");
	property p_ref_gap; gap_r <= GAP_MAX; endproperty
	a_ref_gap: assert property (p_ref_gap) else $error("refresh gap");
	property p_sre_idle; s_sre |-> rp_r == 0 && rfc_r == 0; endproperty
	a_sre_idle: assert property (p_sre_idle) else $error("entry busy");
	property p_sre_odt; s_sre |-> !odt && odt_r >= T_ODTOFF - 1; endproperty
	a_sre_odt: assert property (p_sre_odt) else $error("entry odt");
	property p_sr_hold; s_sre |=> !cke throughout (##[0:4] ck_stop); endproperty
	a_sr_hold: assert property (p_sr_hold) else $error("entry hold");
	property p_cksrx; $rose(cke) |-> run_r >= T_CKSRX; endproperty
	a_cksrx: assert property (p_cksrx) else $error("clock restart");
	property p_srx_nop; s_srx |-> is_nop; endproperty
	a_srx_nop: assert property (p_srx_nop) else $error("exit cmd");
	property p_txs_nop; xs_r != 0 |-> is_nop; endproperty
	a_txs_nop: assert property (p_txs_nop) else $error("txs cmd");
	property p_txsdll; dll_r != 0 |-> cke && !odt; endproperty
	a_txsdll: assert property (p_txsdll) else $error("txsdll pins");
	property p_reentry; s_sre |-> !need_r; endproperty
	a_reentry: assert property (p_reentry) else $error("re-entry");

endmodule : ddrsr_assertions

// ==== dv/ddrsr_tb.sv ====
`timescale 1ns/100ps
`include "ddrsr_regs.svh"

module ddrsr_tb;
	import ddrsr_pkg::*;

	typedef struct {int k; logic signed [15:0] exp;} ddrsr_row_t;
	localparam int T_REFI = 20;
	localparam int T_RFC  = 4;
	localparam int T_XS   = 5;
	localparam int T_XSDLL = 10;
	ddrsr_row_t rows [4] = '{'{1, 1}, '{3, 3}, '{8, 7}, '{10, 7}};

	logic                    clk, rst, sr_req, defer, pull_in, dll_en;
	logic                    banks_open, odt_req, busy_r, c_sr, dll_ready_r;
	logic signed [4:0]       credit_r, cr;
	logic                    ref_active_r, int_ref_r, d_sr, dll_on_r;
	logic                    dll_reset_r, banks_idle_r;
	logic [`DDRSR_ROW_W-1:0] ref_row_r;
	logic [3:0]              bus_cmd;
	int err_count, checks, ext_refs, int_refs, preas, dlls, n, e0, d0;

	ddrsr_if i_ddrsr_if ();
	assign bus_cmd = {i_ddrsr_if.cs_n, i_ddrsr_if.ras_n,
		i_ddrsr_if.cas_n, i_ddrsr_if.we_n};

	ddrsr_ctrl #(.T_REFI(T_REFI), .T_RFC(T_RFC), .T_XS(T_XS),
		.T_XSDLL(T_XSDLL))
	i_ddrsr_ctrl (.clk(clk), .rst(rst), .mem(i_ddrsr_if.ctrl),
		.sr_req(sr_req), .defer(defer), .pull_in(pull_in),
		.banks_open(banks_open), .odt_req(odt_req), .busy_r(busy_r),
		.in_sr_r(c_sr), .dll_ready_r(dll_ready_r), .credit_r(credit_r));

	ddrsr_dram #(.T_RFC(T_RFC), .T_XS(T_XS), .T_REFI(T_REFI))
	i_ddrsr_dram (.clk(clk), .rst(rst), .mem(i_ddrsr_if.dram),
		.dll_en(dll_en), .ref_active_r(ref_active_r), .int_ref_r(int_ref_r),
		.in_sr_r(d_sr), .dll_on_r(dll_on_r), .dll_reset_r(dll_reset_r),
		.banks_idle_r(banks_idle_r), .ref_row_r(ref_row_r));

	ddrsr_assertions #(.T_RFC(T_RFC), .T_REFI(T_REFI), .T_XS(T_XS),
		.T_XSDLL(T_XSDLL)) i_ddrsr_assertions (.clk(clk), .rst(rst),
		.cs_n(i_ddrsr_if.cs_n), .ras_n(i_ddrsr_if.ras_n),
		.cas_n(i_ddrsr_if.cas_n), .we_n(i_ddrsr_if.we_n),
		.cke(i_ddrsr_if.cke), .odt(i_ddrsr_if.odt),
		.ck_stop(i_ddrsr_if.ck_stop));

	// ==========================================================
	// Clock and bus monitor
	always #5 clk = ~clk;

	always @(posedge clk) begin
		if (i_ddrsr_if.cke === 1'b1 && bus_cmd === DDRSR_CMD_REF) ext_refs++;
		if (bus_cmd === DDRSR_CMD_PREA) preas++;
		if (int_ref_r === 1'b1) int_refs++;
		if (dll_reset_r === 1'b1) dlls++;
	end

	// ==========================================================
	// Tasks
	task check(input logic signed [15:0] seen, input logic signed [15:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: saw %0d, expected %0d", $time, seen, exp);
		end
	endtask : check

	task cyc(input int c);
		repeat (c) @(negedge clk);
	endtask : cyc

	task wait_ref;
		e0 = ext_refs;
		for (n = 0; n < 100 && ext_refs == e0; n++) cyc(1);
	endtask : wait_ref

	task drain;
		defer = 1'b0;
		for (n = 0; n < 400 && (credit_r !== 5'sh0 || busy_r !== 1'b0);
		     n++)
			cyc(1);
	endtask : drain

	task summarize;
		$display("Checks %0d, errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : summarize

	// ==========================================================
	// Watchdog
	initial begin
		repeat (5000) @(posedge clk);
		err_count++;
		summarize();
	end

	// ==========================================================
	// Stimulus
	initial begin
		{clk, rst, sr_req, defer, pull_in, banks_open, odt_req} = 7'h21;
		dll_en = 1'b1;
		cyc(10);
		check(i_ddrsr_if.reset_n, 0);
		check(i_ddrsr_if.cke, 0);
		check(credit_r, 0);
		rst = 1'b0;
		for (n = 0; n < 20 && busy_r !== 1'b0; n++) cyc(1);
		check(credit_r, 0);
		check(ref_row_r, 0);
		check(preas, 1);
		foreach (rows[r]) begin
			drain();
			wait_ref();
			check(ref_active_r, 1);
			check(banks_idle_r, 0);
			defer = 1'b1;
			cyc(T_RFC + 1);
			check(banks_idle_r, 1);
			cyc(rows[r].k * T_REFI + T_REFI / 2 - T_RFC - 1);
			check(credit_r, rows[r].exp);
		end
		drain();
		wait_ref();
		d0 = ext_refs;
		repeat (2) begin
			pull_in = 1'b1;
			cyc(1);
			pull_in = 1'b0;
			cyc(5);
		end
		cyc(1);
		check(credit_r, -2);
		check(ext_refs - d0, 2);
		banks_open = 1'b1;
		cyc(1);
		banks_open = 1'b0;
		cyc(3);
		check(preas, 2);
		sr_req = 1'b1;
		for (n = 0; n < 100 && c_sr !== 1'b1; n++) cyc(1);
		check(d_sr, 1);
		check(dll_on_r, 0);
		check(i_ddrsr_if.odt, 0);
		cr = credit_r;
		d0 = int_refs;
		pull_in = 1'b1;
		cyc(1);
		pull_in = 1'b0;
		cyc(3 * T_REFI - 1);
		check(int_refs - d0, 3);
		check(credit_r, cr);
		sr_req = 1'b0;
		for (n = 0; n < 20 && c_sr !== 1'b0; n++) cyc(1);
		d0 = dlls;
		e0 = ext_refs;
		sr_req = 1'b1;
		for (n = 0; n < 200 && c_sr !== 1'b1; n++) cyc(1);
		check(c_sr, 1);
		check(ext_refs > e0, 1);
		check(dlls - d0, 1);
		sr_req = 1'b0;
		for (n = 0; n < 100 && dll_ready_r !== 1'b1; n++) cyc(1);
		check(dll_ready_r, 1);
		check(dll_on_r, 1);
		dll_en = 1'b0;
		d0 = dlls;
		sr_req = 1'b1;
		for (n = 0; n < 100 && c_sr !== 1'b1; n++) cyc(1);
		check(d_sr, 1);
		sr_req = 1'b0;
		for (n = 0; n < 20 && c_sr !== 1'b0; n++) cyc(1);
		cyc(20);
		check(dlls - d0, 0);
		check(dll_on_r, 0);
		check(ref_row_r, ext_refs + int_refs);
		summarize();
	end

endmodule : ddrsr_tb
